// *** logic/sdg_status_diag.sv ***
/*
 sdg_status_diag: status cable lines (mapped, forced by link command or by register)
 and the diagnostic register that drives the housekeeping adc.
 assumes a synchronous register port, link commands decoded to one-cycle pulses,
 and monitored conditions synchronous to clk.
*/
// Contract
// - all-zero mappings keep status lines low
// - mapping bit 28 sets line directly
// - command 0x3a forces all lines high
// - command 0x3b forces all lines low
// - command 0x3c restores mapped reporting
// - diag bit 29 cancels any forcing
// - diag bits 20..18 select adc channel
// - each diag write starts a conversion
// - diag reads return that result once bit 8 is set
// - diag bit 8 flags conversion complete
// - diag bits 7..0 hold adc result
// - channels three and six: ecl supplies
// - channels one and two: board temperatures
// - channel zero: optical receive power
// - mapped line is or of selected conditions
// - latches clear by bit 21 or 0x3e
`timescale 1ns/1ps
`include "sdg_regs.svh"
module sdg_status_diag import sdg_pkg::*; #(
    parameter int NCOND = `SDG_MAP_SEL_W,
    parameter logic [NCOND-1:0] LATCH_MASK = '1,
    parameter int START_CYC = `SDG_ADC_START_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [`SDG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire sdg_cmd_t link_cmd,
    input wire logic [NCOND-1:0] cond_in,
    input wire sdg_adc_in_t adc_in,
    output sdg_adc_out_t adc_out,
    output logic [`SDG_NUM_LINES-1:0] status_out
);
    // the external analog mux is wired so that these channel codes hold:
    // optical power, top and bottom temperature, ecl main and termination supply
    localparam logic [2:0] CH_OPT = `SDG_CH_OPT_POWER;
    localparam logic [2:0] CH_TTOP = `SDG_CH_TEMP_TOP;
    localparam logic [2:0] CH_TBOT = `SDG_CH_TEMP_BOT;
    localparam logic [2:0] CH_EMAIN = `SDG_CH_ECL_MAIN;
    localparam logic [2:0] CH_ETERM = `SDG_CH_ECL_TERM;

    logic [31:0] map_r [`SDG_NUM_LINES];
    logic [31:0] map_nxt [`SDG_NUM_LINES];
    logic [2:0] ch_r, ch_nxt;
    sdg_force_t force_r, force_nxt;
    logic [`SDG_NUM_LINES-1:0] status_r, status_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;

    logic diag_wr, erst_w, latch_clr;
    logic [NCOND-1:0] cond_eff;
    logic adc_done;
    logic [7:0] adc_result;

    assign diag_wr = reg_wr && reg_addr == `SDG_OFF_DIAG;
    assign erst_w = diag_wr && reg_wdata[`SDG_DIAG_ERST_BIT];
    assign latch_clr = (diag_wr && reg_wdata[`SDG_DIAG_LRST_BIT]) ||
                       (link_cmd.valid && link_cmd.code == `SDG_CMD_LATCH_CLR);

    sdg_err_latch #(
        .N(NCOND),
        .LATCH_MASK(LATCH_MASK)
    ) u_latch (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .cond_in(cond_in),
        .clr(latch_clr),
        .cond_out(cond_eff)
    );

    sdg_adc_ctrl #(
        .START_CYC(START_CYC)
    ) u_adc (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .start_req(diag_wr),
        .ch_in(reg_wdata[`SDG_DIAG_CH_HI:`SDG_DIAG_CH_LO]),
        .adc_in(adc_in),
        .adc_out(adc_out),
        .done(adc_done),
        .result(adc_result)
    );

    // register writes
    always_comb begin
        for (int i = 0; i < `SDG_NUM_LINES; i++) begin
            map_nxt[i] = map_r[i];
        end
        ch_nxt = ch_r;
        if (reg_wr) begin
            if (reg_addr == `SDG_OFF_MAP0) begin
                map_nxt[0] = reg_wdata;
            end else if (reg_addr == `SDG_OFF_MAP1) begin
                map_nxt[1] = reg_wdata;
            end else if (reg_addr == `SDG_OFF_MAP2) begin
                map_nxt[2] = reg_wdata;
            end else if (reg_addr == `SDG_OFF_MAP3) begin
                map_nxt[3] = reg_wdata;
            end else if (reg_addr == `SDG_OFF_DIAG) begin
                ch_nxt = reg_wdata[`SDG_DIAG_CH_HI:`SDG_DIAG_CH_LO];
            end
        end
    end

    // forcing state; the register reset wins over a link command in the same cycle
    always_comb begin
        force_nxt = force_r;
        if (erst_w) begin
            force_nxt = sdg_force_none;
        end else if (link_cmd.valid) begin
            case (link_cmd.code)
                `SDG_CMD_FORCE_HIGH: force_nxt = sdg_force_high;
                `SDG_CMD_FORCE_LOW: force_nxt = sdg_force_low;
                `SDG_CMD_NORMAL: force_nxt = sdg_force_none;
                default: force_nxt = force_r;
            endcase
        end
    end

    // lines follow the next mapping and forcing so a change shows one cycle later
    always_comb begin
        for (int i = 0; i < `SDG_NUM_LINES; i++) begin
            status_nxt[i] = |(map_nxt[i][NCOND-1:0] & cond_eff) |
                            map_nxt[i][`SDG_MAP_SET_BIT];
        end
        case (force_nxt)
            sdg_force_high: status_nxt = '1;
            sdg_force_low: status_nxt = '0;
            default: status_nxt = status_nxt;
        endcase
    end

    // read path: one cycle latency, unmapped reads return zero
    always_comb begin
        rdata_nxt = rdata_r;
        ack_nxt = reg_wr || reg_rd;
        if (reg_rd) begin
            rdata_nxt = 32'h0000_0000;
            if (reg_addr == `SDG_OFF_MAP0) begin
                rdata_nxt = map_r[0];
            end else if (reg_addr == `SDG_OFF_MAP1) begin
                rdata_nxt = map_r[1];
            end else if (reg_addr == `SDG_OFF_MAP2) begin
                rdata_nxt = map_r[2];
            end else if (reg_addr == `SDG_OFF_MAP3) begin
                rdata_nxt = map_r[3];
            end else if (reg_addr == `SDG_OFF_DIAG) begin
                rdata_nxt[`SDG_DIAG_CH_HI:`SDG_DIAG_CH_LO] = ch_r;
                rdata_nxt[`SDG_DIAG_DONE_BIT] = adc_done;
                rdata_nxt[7:0] = adc_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < `SDG_NUM_LINES; i++) begin
                map_r[i] <= `SDG_MAP_RST;
            end
            ch_r <= `SDG_DIAG_CH_RST;
            force_r <= sdg_force_none;
            status_r <= '0;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < `SDG_NUM_LINES; i++) begin
                map_r[i] <= map_nxt[i];
            end
            ch_r <= ch_nxt;
            force_r <= force_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign status_out = status_r;
    assign reg_rdata = rdata_r;
    assign reg_ack = ack_r;

    // width of the running adc start pulse; only the pulse-width check reads it
    logic [7:0] start_len_r;
    logic [7:0] start_len_nxt;

    always_comb begin
        start_len_nxt = start_len_r;
        if (diag_wr) begin
            start_len_nxt = 8'h00;
        end else if (adc_out.start && start_len_r != 8'hff) begin
            start_len_nxt = start_len_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_len_r <= 8'h00;
        end else if (ce) begin
            start_len_r <= start_len_nxt;
        end
    end

    sequence s_cmd(logic [7:0] c);
        ce && link_cmd.valid && link_cmd.code == c && !erst_w;
    endsequence
    sequence s_quiet;
        ce && !link_cmd.valid && !reg_wr;
    endsequence

    a_force_high_all: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_FORCE_HIGH) |=> status_out == 4'hf && force_r == sdg_force_high)
        else $error("force high command not applied");
    a_force_low_all: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_FORCE_LOW) |=> status_out == 4'h0 && force_r == sdg_force_low)
        else $error("force low command not applied");
    a_force_hold: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_FORCE_HIGH) ##1 s_quiet[*3] |=> status_out == 4'hf)
        else $error("forced high not held");
    a_normal_back: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_NORMAL) |=> force_r == sdg_force_none)
        else $error("normal command did not end forcing");
    a_erst_cancel: assert property (@(posedge clk) disable iff (!resetn)
        ce && erst_w |=> force_r == sdg_force_none)
        else $error("error logic reset did not cancel forcing");
    a_zero_maps: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet and (force_r == sdg_force_none && map_r[0] == '0 && map_r[1] == '0 &&
        map_r[2] == '0 && map_r[3] == '0) |=> status_out == 4'h0)
        else $error("status line driven with all mappings cleared");
    a_set_bit: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet and (force_r == sdg_force_none && map_r[1][`SDG_MAP_SET_BIT]) |=> status_out[1])
        else $error("direct set bit did not raise the line");
    a_map_or: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet and (force_r == sdg_force_none) |=> status_out[0] ==
        ($past(|(map_r[0][NCOND-1:0] & cond_eff)) | $past(map_r[0][`SDG_MAP_SET_BIT])))
        else $error("mapped line is not the or of selected conditions");
    a_diag_read: assert property (@(posedge clk) disable iff (!resetn)
        ce && reg_rd && reg_addr == `SDG_OFF_DIAG |=> reg_ack &&
        reg_rdata[7:0] == $past(adc_result) && reg_rdata[`SDG_DIAG_DONE_BIT] == $past(adc_done))
        else $error("diagnostic read does not return adc state");

    // forcing state and lines come from one next value, so they agree in every cycle
    a_high_lines: assert property (@(posedge clk) disable iff (!resetn)
        force_r == sdg_force_high |-> status_out == 4'hf)
        else $error("forced high state with a line low");

    a_low_lines: assert property (@(posedge clk) disable iff (!resetn)
        force_r == sdg_force_low |-> status_out == 4'h0)
        else $error("forced low state with a line high");

    a_force_keep: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet and (force_r != sdg_force_none) |=> force_r == $past(force_r))
        else $error("forcing changed without a command or reset");

    a_low_hold: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_FORCE_LOW) ##1 s_quiet[*3] |=> status_out == 4'h0)
        else $error("forced low not held");

    a_normal_lines: assert property (@(posedge clk) disable iff (!resetn)
        s_cmd(`SDG_CMD_NORMAL) and (!reg_wr) |=> status_out[3] ==
        ($past(|(map_r[3][NCOND-1:0] & cond_eff)) | $past(map_r[3][`SDG_MAP_SET_BIT])))
        else $error("normal command did not return the line to its mapping");

    a_erst_lines: assert property (@(posedge clk) disable iff (!resetn)
        ce && erst_w |=> status_out[0] ==
        ($past(|(map_r[0][NCOND-1:0] & cond_eff)) | $past(map_r[0][`SDG_MAP_SET_BIT])))
        else $error("error logic reset left a line forced");

    // no disable here: the check is about what reset itself leaves behind
    a_reset_normal: assert property (@(posedge clk)
        !resetn |=> force_r == sdg_force_none && status_out == 4'h0 && !reg_ack && !adc_out.start)
        else $error("reset did not leave unforced mapped reporting");

    a_chan_store: assert property (@(posedge clk) disable iff (!resetn)
        ce && diag_wr |=> ch_r == $past(reg_wdata[`SDG_DIAG_CH_HI:`SDG_DIAG_CH_LO]))
        else $error("channel field not stored on diagnostic write");

    a_diag_layout: assert property (@(posedge clk) disable iff (!resetn)
        ce && reg_rd && reg_addr == `SDG_OFF_DIAG |=> reg_rdata[31:21] == 11'h000 &&
        reg_rdata[17:9] == 9'h000 && reg_rdata[`SDG_DIAG_CH_HI:`SDG_DIAG_CH_LO] == $past(ch_r))
        else $error("diagnostic read fields out of place");

    a_set_clear: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet and (force_r == sdg_force_none && map_r[1] == '0) |=> !status_out[1])
        else $error("line with a cleared mapping is still driven");

    a_latch_cmd: assert property (@(posedge clk) disable iff (!resetn)
        ce && latch_clr && cond_in == '0 |=> (cond_eff & LATCH_MASK) == '0)
        else $error("latched conditions survive a clear");

    a_start_width: assert property (@(posedge clk) disable iff (!resetn)
        $fell(adc_out.start) |-> start_len_r == 8'(START_CYC))
        else $error("adc start pulse has the wrong width");

    a_reg_answer: assert property (@(posedge clk) disable iff (!resetn)
        ce |=> reg_ack == $past(reg_wr || reg_rd))
        else $error("register access not answered in one cycle");
endmodule

// *** logic/sdg_regs.svh ***
/*
 sdg_regs.svh: register offsets, field positions, reset values, command codes,
 adc channel assignment and timing counts for the status-line and adc diagnostic block.
 assumes a 100 MHz clock; definitions only.
*/
`ifndef SDG_REGS_SVH
`define SDG_REGS_SVH

`define SDG_ADDR_W 16
`define SDG_OFF_MAP0 16'h0008
`define SDG_OFF_MAP1 16'h000c
`define SDG_OFF_MAP2 16'h0010
`define SDG_OFF_MAP3 16'h0014
`define SDG_OFF_DIAG 16'h0020

`define SDG_NUM_LINES 4
`define SDG_MAP_SEL_W 28
`define SDG_MAP_SET_BIT 28
`define SDG_MAP_RST 32'h0000_0000

`define SDG_DIAG_ERST_BIT 29
`define SDG_DIAG_LRST_BIT 21
`define SDG_DIAG_CH_HI 20
`define SDG_DIAG_CH_LO 18
`define SDG_DIAG_DONE_BIT 8
`define SDG_DIAG_CH_RST 3'h0

`define SDG_CMD_FORCE_HIGH 8'h3a
`define SDG_CMD_FORCE_LOW 8'h3b
`define SDG_CMD_NORMAL 8'h3c
`define SDG_CMD_LATCH_CLR 8'h3e

`define SDG_CH_OPT_POWER 3'h0
`define SDG_CH_TEMP_TOP 3'h1
`define SDG_CH_TEMP_BOT 3'h2
`define SDG_CH_ECL_MAIN 3'h3
`define SDG_CH_ECL_TERM 3'h6

`define SDG_CLK_NS 10
`define SDG_ADC_START_NS 250
`define SDG_ADC_START_CYC ((`SDG_ADC_START_NS + `SDG_CLK_NS - 1) / `SDG_CLK_NS)

`endif

// *** logic/sdg_pkg.sv ***
/*
 sdg_pkg: types shared by the status-line and adc diagnostic block.
 assumes nothing beyond a systemverilog compiler.
*/
package sdg_pkg;

    typedef enum logic [1:0] {
        sdg_force_none,
        sdg_force_high,
        sdg_force_low
    } sdg_force_t;

    typedef enum logic [1:0] {
        sdg_adc_idle,
        sdg_adc_start,
        sdg_adc_wait_low,
        sdg_adc_wait_high
    } sdg_adc_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } sdg_cmd_t;

    typedef struct packed {
        logic start;
        logic [2:0] sel;
    } sdg_adc_out_t;

    typedef struct packed {
        logic eoc;
        logic [7:0] data;
    } sdg_adc_in_t;

endpackage

// *** logic/sdg_err_latch.sv ***
/*
 sdg_err_latch: holds the latched monitored conditions until cleared.
 assumes conditions synchronous to clk; clr is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "sdg_regs.svh"
module sdg_err_latch import sdg_pkg::*; #(
    parameter int N = `SDG_MAP_SEL_W,
    parameter logic [N-1:0] LATCH_MASK = '1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [N-1:0] cond_in,
    input wire logic clr,
    output logic [N-1:0] cond_out
);
    logic [N-1:0] latch_r;
    logic [N-1:0] latch_nxt;

    // a condition present in the clear cycle survives the clear
    always_comb begin
        if (clr) begin
            latch_nxt = cond_in & LATCH_MASK;
        end else begin
            latch_nxt = (latch_r | cond_in) & LATCH_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            latch_r <= '0;
        end else if (ce) begin
            latch_r <= latch_nxt;
        end
    end

    assign cond_out = (cond_in & ~LATCH_MASK) | latch_r;

    a_latch_hold: assert property (@(posedge clk) disable iff (!resetn)
        ce && !clr && |(cond_in & LATCH_MASK) |=> (latch_r & $past(cond_in & LATCH_MASK)) == $past(cond_in & LATCH_MASK))
        else $error("latched condition lost without clear");
    a_latch_clear: assert property (@(posedge clk) disable iff (!resetn)
        ce && clr && cond_in == '0 |=> latch_r == '0)
        else $error("latch not cleared");
endmodule

// *** logic/sdg_adc_ctrl.sv ***
/*
 sdg_adc_ctrl: runs one conversion of the external 8-channel adc per request.
 assumes the adc drops eoc after start and raises it when the result is valid.
*/
`timescale 1ns/1ps
`include "sdg_regs.svh"
module sdg_adc_ctrl import sdg_pkg::*; #(
    parameter int START_CYC = `SDG_ADC_START_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic start_req,
    input wire logic [2:0] ch_in,
    input wire sdg_adc_in_t adc_in,
    output sdg_adc_out_t adc_out,
    output logic done,
    output logic [7:0] result
);
    sdg_adc_state_t state_r, state_nxt;
    sdg_adc_out_t out_r, out_nxt;
    logic done_r, done_nxt;
    logic [7:0] res_r, res_nxt;
    logic [7:0] cnt_r, cnt_nxt;

    // a new request restarts the converter even mid-conversion
    always_comb begin
        state_nxt = state_r;
        out_nxt = out_r;
        done_nxt = done_r;
        res_nxt = res_r;
        cnt_nxt = cnt_r;
        if (start_req) begin
            state_nxt = sdg_adc_start;
            out_nxt.sel = ch_in;
            out_nxt.start = 1'b1;
            done_nxt = 1'b0;
            cnt_nxt = 8'(START_CYC - 1);
        end else begin
            case (state_r)
                sdg_adc_start: begin
                    if (cnt_r == 8'h00) begin
                        out_nxt.start = 1'b0;
                        state_nxt = sdg_adc_wait_low;
                    end else begin
                        cnt_nxt = cnt_r - 8'h01;
                    end
                end
                sdg_adc_wait_low: begin
                    if (!adc_in.eoc) begin
                        state_nxt = sdg_adc_wait_high;
                    end
                end
                sdg_adc_wait_high: begin
                    if (adc_in.eoc) begin
                        res_nxt = adc_in.data;
                        done_nxt = 1'b1;
                        state_nxt = sdg_adc_idle;
                    end
                end
                default: begin
                    state_nxt = sdg_adc_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= sdg_adc_idle;
            out_r <= '0;
            done_r <= 1'b0;
            res_r <= 8'h00;
            cnt_r <= 8'h00;
        end else if (ce) begin
            state_r <= state_nxt;
            out_r <= out_nxt;
            done_r <= done_nxt;
            res_r <= res_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign adc_out = out_r;
    assign done = done_r;
    assign result = res_r;

    a_adc_start: assert property (@(posedge clk) disable iff (!resetn)
        ce && start_req |=> adc_out.start && !done && adc_out.sel == $past(ch_in))
        else $error("write did not start conversion on selected channel");
    a_adc_result: assert property (@(posedge clk) disable iff (!resetn)
        ce && !start_req && state_r == sdg_adc_wait_high && adc_in.eoc |=> done && result == $past(adc_in.data))
        else $error("conversion result not captured");
endmodule

// *** test/sdg_adc_model.sv ***
/*
 sdg_adc_model: behavioural stand-in for the housekeeping adc and its analog inputs.
 assumes adc_out from the block under test and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sdg_adc_model import sdg_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire sdg_adc_out_t adc_out,
    output sdg_adc_in_t adc_in
);
    logic eoc_r = 1'b1;
    logic busy_r = 1'b0;
    logic [7:0] val_r = 8'h00;
    int cnt_r = 0;

    // each channel carries its own level so a wrong mux select shows up in the code
    always @(posedge clk) begin
        if (!resetn) begin
            eoc_r <= 1'b1;
            busy_r <= 1'b0;
            cnt_r <= 0;
        end else if (adc_out.start) begin
            eoc_r <= 1'b0;
            busy_r <= 1'b1;
            cnt_r <= slow ? 20 : 1;
            val_r <= 8'ha8 + {5'h00, adc_out.sel};
        end else if (busy_r) begin
            if (cnt_r == 0) begin
                eoc_r <= 1'b1;
                busy_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1;
            end
        end
    end

    // data is not valid while converting, so show the inverse rather than a stale code
    assign adc_in = '{eoc: eoc_r, data: eoc_r ? val_r : ~val_r};
endmodule

// *** test/tb_sdg_status_diag.sv ***
/*
 tb_sdg_status_diag: self-checking bench for the status lines and the diagnostic adc.
 assumes the design files under logic/ and the adc model under test/.
*/
`timescale 1ns/1ps
`include "sdg_regs.svh"
module tb_sdg_status_diag import sdg_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic adc_slow = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_ack;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [27:0] cond_in = 28'h000_0000;
    logic [3:0] status_out;
    sdg_cmd_t link_cmd = '0;
    sdg_adc_in_t adc_in;
    sdg_adc_out_t adc_out;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    sdg_status_diag #(.START_CYC(2)) u_dut (
        .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .link_cmd(link_cmd), .cond_in(cond_in), .adc_in(adc_in), .adc_out(adc_out),
        .status_out(status_out)
    );

    sdg_adc_model u_adc (.clk(clk), .resetn(resetn), .slow(adc_slow), .adc_out(adc_out), .adc_in(adc_in));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // generous ceiling: the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_ack();
        int n;
        // the ack is registered on the very edge that takes the strobe
        #1;
        for (n = 0; n < 5 && reg_ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("reg_ack", 32'h1, {31'h0, reg_ack});
    endtask

    task automatic reg_write(logic [15:0] addr, logic [31:0] data);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
        wait_ack();
    endtask

    task automatic reg_read(logic [15:0] addr, output logic [31:0] data);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd <= 1'b0;
        wait_ack();
        data = reg_rdata;
    endtask

    task automatic send_cmd(logic [7:0] code);
        @(posedge clk);
        link_cmd <= '{valid: 1'b1, code: code};
        @(posedge clk);
        link_cmd <= '0;
        @(posedge clk);
        #1;
    endtask

    task automatic settle_status(logic [3:0] exp);
        repeat (3) @(posedge clk);
        #1;
        check("status_out", {28'h0, exp}, {28'h0, status_out});
    endtask

    task automatic test_reset_state();
        logic [31:0] d;
        check("status_out after reset", 32'h0, {28'h0, status_out});
        reg_read(`SDG_OFF_DIAG, d);
        check("diag after reset", 32'h0, d);
        reg_read(16'h0030, d);
        check("unmapped read", 32'h0, d);
    endtask

    task automatic test_mapping();
        cond_in <= 28'hfff_ffff;
        reg_write(`SDG_OFF_MAP0, 32'h0);
        reg_write(`SDG_OFF_MAP1, 32'h0);
        reg_write(`SDG_OFF_MAP2, 32'h0);
        reg_write(`SDG_OFF_MAP3, 32'h0);
        settle_status(4'h0);
        reg_write(`SDG_OFF_MAP2, 32'h1000_0000);
        settle_status(4'h4);
        reg_write(`SDG_OFF_MAP2, 32'h0);
        settle_status(4'h0);
        cond_in <= 28'h000_0000;
        reg_write(`SDG_OFF_DIAG, 32'h0020_0000);
        reg_write(`SDG_OFF_MAP1, 32'h0000_0018);
        settle_status(4'h0);
        cond_in <= 28'h000_0010;
        @(posedge clk);
        cond_in <= 28'h000_0000;
        settle_status(4'h2);
        send_cmd(`SDG_CMD_LATCH_CLR);
        settle_status(4'h0);
    endtask

    task automatic test_forcing();
        // 8'h00 in the table stands for a diagnostic write with the error-logic reset bit
        logic [7:0] codes [8] = '{8'h3a, 8'h3b, 8'h3a, 8'h3c, 8'h3b, 8'h00, 8'h3a, 8'h00};
        logic [3:0] exps [8] = '{4'hf, 4'h0, 4'hf, 4'h1, 4'h0, 4'h1, 4'hf, 4'h1};
        int i;
        reg_write(`SDG_OFF_MAP0, 32'h1000_0000);
        settle_status(4'h1);
        for (i = 0; i < 8; i++) begin
            if (codes[i] == 8'h00) begin
                reg_write(`SDG_OFF_DIAG, 32'h2000_0000);
                #1;
            end else begin
                send_cmd(codes[i]);
            end
            check("forced status", {28'h0, exps[i]}, {28'h0, status_out});
            settle_status(exps[i]);
        end
        send_cmd(8'h3d);
        check("unknown command", 32'h1, {28'h0, status_out});
        ce <= 1'b0;
        send_cmd(`SDG_CMD_FORCE_HIGH);
        ce <= 1'b1;
        settle_status(4'h1);
    endtask

    task automatic convert(logic [2:0] ch);
        logic [31:0] d;
        logic [31:0] exp;
        int n;
        exp = {11'h0, ch, 10'h001, 8'ha8 + {5'h00, ch}};
        reg_write(`SDG_OFF_DIAG, {11'h0, ch, 18'h0});
        reg_read(`SDG_OFF_DIAG, d);
        check("done right after start", 32'h0, {31'h0, d[`SDG_DIAG_DONE_BIT]});
        for (n = 0; n < 40; n++) begin
            reg_read(`SDG_OFF_DIAG, d);
            if (d[`SDG_DIAG_DONE_BIT] === 1'b1) begin
                break;
            end
        end
        check("diag result", exp, d);
    endtask

    task automatic test_adc();
        logic [2:0] chans [5] = '{`SDG_CH_ECL_MAIN, `SDG_CH_ECL_TERM, `SDG_CH_TEMP_TOP, `SDG_CH_TEMP_BOT, `SDG_CH_OPT_POWER};
        int i;
        for (i = 0; i < 5; i++) begin
            adc_slow <= i[0];
            convert(chans[i]);
        end
        adc_slow <= 1'b1;
        convert(3'h7);
        adc_slow <= 1'b0;
    endtask

    task automatic test_midrun_reset();
        logic [31:0] d;
        send_cmd(`SDG_CMD_FORCE_HIGH);
        check("forced before reset", 32'hf, {28'h0, status_out});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check("status after mid-run reset", 32'h0, {28'h0, status_out});
        reg_read(`SDG_OFF_DIAG, d);
        check("diag after mid-run reset", 32'h0, d);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        test_reset_state();
        test_mapping();
        test_forcing();
        test_adc();
        test_midrun_reset();
        wrap_up();
    end
endmodule
